/* File: verilog/ctpr_regs.sv */
// Thermal-regulation and protection-command register bank
`timescale 1ns/1ps
`default_nettype none
module ctpr_regs #(
  parameter logic THM_OFF_RST = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Host register access
  input wire logic wr_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // Supply monitors
  input wire logic standby_supply,
  input wire logic safe_output_power_good,
  // Analog loop controls and unlock status
  output logic temp_loop_en,
  output ctpr_pkg::ctpr_setpt_t die_temp_setpoint,
  output logic thermistor_monitor_off,
  output logic safety_region_select,
  output logic setting_unlocked
);
  import ctpr_pkg::*;
  ctpr_wr_if wr();
  logic [1:0] key;
  logic pg_q;
  logic [1:0] setpt_q;
  logic thm_q;
  logic safe_q;
  logic thm_wr;
  logic stby_lost;
  logic pg_rise;
  logic therm_hit;
  logic prot_hit;
  logic [1:0] setpt_d;
  logic thm_d;
  logic safe_d;
  logic [7:0] therm_view;
  logic [7:0] prot_view;

  // Power-good edge caught on the clock; inputs treated as synchronous
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_q <= 1'b0;
    end else begin
      pg_q <= safe_output_power_good;
    end
  end

  // Standby loss is a held level; power-good counts only on its rising edge
  assign stby_lost = !standby_supply;
  assign pg_rise = safe_output_power_good && !pg_q;
  assign wr.rst_evt = stby_lost || pg_rise;
  assign wr.wr_en = wr_en;
  assign wr.addr = addr;
  assign wr.wdata = wdata;

  ctpr_lock u_lock (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr(wr),
    .key(key)
  );

  assign therm_hit = (addr == CTPR_ADDR_THERM);
  assign prot_hit = (addr == CTPR_ADDR_PROT);
  // Guarded register takes a write only while the key reads unlocked
  assign thm_wr = wr_en && therm_hit && wr.unlocked;

  // Reset event outranks a host write landing in the same cycle
  always_comb begin
    setpt_d = setpt_q;
    if (wr.rst_evt) begin
      setpt_d = CTPR_SETPT_RST;
    end else if (thm_wr) begin
      setpt_d = wdata[CTPR_SETPT_LSB +: 2];
    end
  end

  always_comb begin
    thm_d = thm_q;
    if (wr.rst_evt) begin
      thm_d = THM_OFF_RST;
    end else if (thm_wr) begin
      thm_d = wdata[CTPR_THM_BIT];
    end
  end

  always_comb begin
    safe_d = safe_q;
    if (wr.rst_evt) begin
      safe_d = CTPR_SAFE_RST;
    end else if (thm_wr) begin
      safe_d = wdata[CTPR_SAFE_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      setpt_q <= CTPR_SETPT_RST;
    end else begin
      setpt_q <= setpt_d;
    end
  end

  // Variant default of the thermistor bit comes in as a parameter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      thm_q <= THM_OFF_RST;
    end else begin
      thm_q <= thm_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      safe_q <= CTPR_SAFE_RST;
    end else begin
      safe_q <= safe_d;
    end
  end

  // Reserved positions are not stored, so they read zero
  always_comb begin
    therm_view = 8'h00;
    therm_view[CTPR_SETPT_LSB +: 2] = setpt_q;
    therm_view[CTPR_THM_BIT] = thm_q;
    therm_view[CTPR_SAFE_BIT] = safe_q;
  end

  always_comb begin
    prot_view = 8'h00;
    prot_view[CTPR_KEY_LSB +: 2] = key;
  end

  // Unmapped addresses read zero
  always_comb begin
    rdata = 8'h00;
    case (addr)
      CTPR_ADDR_THERM: begin
        rdata = therm_view;
      end
      CTPR_ADDR_PROT: begin
        rdata = prot_view;
      end
      default: begin
        rdata = 8'h00;
      end
    endcase
  end

  assign die_temp_setpoint = ctpr_setpt_t'(setpt_q);
  assign temp_loop_en = (setpt_q != CTPR_TOFF);
  assign thermistor_monitor_off = thm_q;
  assign safety_region_select = safe_q;
  assign setting_unlocked = wr.unlocked;

  a_locked_ignore: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_en && therm_hit && !setting_unlocked && !wr.rst_evt)
    |=> $stable(setpt_q) && $stable(thm_q) && $stable(safe_q))
    else $error("locked write changed thermal register");
  a_unlocked_take: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (thm_wr && !wr.rst_evt) |=> setpt_q == $past(wdata[7:6]) && safe_q == $past(wdata[0]))
    else $error("unlocked write not stored");
  a_evt_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr.rst_evt |=> setpt_q == 2'h0 && safe_q == 1'b0 && key == 2'h0 && thm_q == THM_OFF_RST)
    else $error("reset event did not restore defaults");
  a_loop_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    therm_hit |-> temp_loop_en == (rdata[7:6] != 2'h3))
    else $error("loop enable disagrees with setpoint");
  a_thm_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    therm_hit |-> rdata[3] == thermistor_monitor_off)
    else $error("thermistor bit mismatch");
  a_region_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    therm_hit |-> rdata[0] == safety_region_select)
    else $error("region bit mismatch");
  a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (addr == CTPR_ADDR_THERM ? (rdata & 8'h36) == 8'h00 : (rdata & 8'hf3) == 8'h00))
    else $error("reserved bits not zero");
  a_thm_take: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (thm_wr && !wr.rst_evt) |=> thm_q == $past(wdata[3]))
    else $error("thermistor bit not stored");
  a_setpt_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    therm_hit |-> die_temp_setpoint == rdata[7:6])
    else $error("setpoint output disagrees with register");
  a_key_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    prot_hit |-> setting_unlocked == (rdata[3:2] == 2'h3))
    else $error("unlock flag disagrees with key readback");
  a_key_take: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_en && prot_hit && !wr.rst_evt) |=> key == $past(wdata[3:2]))
    else $error("key write not stored");
  a_prot_unguarded: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_en && prot_hit && !setting_unlocked && wdata[3:2] == 2'h3 && !wr.rst_evt) |=> setting_unlocked)
    else $error("key register refused a write while locked");
  a_other_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_en && !therm_hit && !wr.rst_evt) |=> $stable(setpt_q) && $stable(thm_q) && $stable(safe_q))
    else $error("stray write changed thermal register");
  a_pg_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (safe_output_power_good && pg_q && standby_supply && thm_wr) |=> setpt_q == $past(wdata[7:6]))
    else $error("held power-good cleared a write");
  a_stby_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stby_lost |=> !setting_unlocked && temp_loop_en)
    else $error("standby loss left settings in place");

  // One reserved-bit check per readback position
  for (genvar b = 0; b < 8; b++) begin : g_rsvd
    localparam bit THERM_USED = (b >= CTPR_SETPT_LSB) || (b == CTPR_THM_BIT) || (b == CTPR_SAFE_BIT);
    localparam bit PROT_USED = (b >= CTPR_KEY_LSB) && (b < CTPR_KEY_LSB + 2);
    a_rsvd_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (therm_hit ? !THERM_USED : (prot_hit ? !PROT_USED : 1'b1)) |-> !rdata[b])
      else $error("reserved readback bit set");
  end
endmodule
`default_nettype wire

/* File: verilog/ctpr_pkg.sv */
// Package with register map, field layout and reset values of the thermal/protection bank
`default_nettype none
package ctpr_pkg;
  localparam logic [7:0] CTPR_ADDR_THERM = 8'h09;
  localparam logic [7:0] CTPR_ADDR_PROT = 8'h0a;
  // Thermal register fields
  localparam int CTPR_SETPT_LSB = 6;
  localparam int CTPR_THM_BIT = 3;
  localparam int CTPR_SAFE_BIT = 0;
  // Protection register key field
  localparam int CTPR_KEY_LSB = 2;
  localparam logic [1:0] CTPR_KEY_UNLOCK = 2'h3;
  localparam logic [1:0] CTPR_KEY_RST = 2'h0;
  localparam logic [1:0] CTPR_SETPT_RST = 2'h0;
  localparam logic CTPR_SAFE_RST = 1'b0;
  typedef enum logic [1:0] {
    CTPR_T105 = 2'h0,
    CTPR_T90 = 2'h1,
    CTPR_T120 = 2'h2,
    CTPR_TOFF = 2'h3
  } ctpr_setpt_t;
endpackage
`default_nettype wire

/* File: verilog/ctpr_wr_if.sv */
// Interface carrying the raw host write, reset event and unlock flag between the bank and the key register
`timescale 1ns/1ps
`default_nettype none
interface ctpr_wr_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic unlocked;
  logic rst_evt;
  modport src (output wr_en, output addr, output wdata, output rst_evt, input unlocked);
  modport dst (input wr_en, input addr, input wdata, input rst_evt, output unlocked);
endinterface
`default_nettype wire

/* File: verilog/ctpr_lock.sv */
// Protection-key register that gates writes to guarded settings
`timescale 1ns/1ps
`default_nettype none
module ctpr_lock (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Write channel
  ctpr_wr_if.dst wr,
  // Key readback
  output logic [1:0] key
);
  import ctpr_pkg::*;
  logic [1:0] key_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_q <= CTPR_KEY_RST;
    end else if (wr.rst_evt) begin
      key_q <= CTPR_KEY_RST;
    end else if (wr.wr_en && wr.addr == CTPR_ADDR_PROT) begin
      key_q <= wr.wdata[CTPR_KEY_LSB +: 2];
    end
  end

  assign key = key_q;
  assign wr.unlocked = (key_q == CTPR_KEY_UNLOCK);

  a_key_unlock: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr.wr_en && wr.addr == CTPR_ADDR_PROT && wr.wdata[3:2] == 2'h3 && !wr.rst_evt) |=> wr.unlocked)
    else $error("key 11 did not unlock");
  a_key_relock: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr.wr_en && wr.addr == CTPR_ADDR_PROT && wr.wdata[3:2] != 2'h3 && !wr.rst_evt) |=> !wr.unlocked)
    else $error("non-11 key left bank unlocked");
endmodule
`default_nettype wire

/* File: dv/ctpr_host.sv */
// Host model issuing register writes and read addresses
`timescale 1ns/1ps
`default_nettype none
module ctpr_host (
  // Bus
  input wire logic ref_clk,
  output logic wr_en,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  initial begin
    wr_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge ref_clk);
    wr_en = 1'b0;
    wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    addr = a;
    #1;
  endtask
endmodule
`default_nettype wire

/* File: dv/ctpr_regs_bench.sv */
// Bench for the thermal and protection register bank
`timescale 1ns/1ps
`default_nettype none
module ctpr_regs_bench;
  import ctpr_pkg::*;
  logic ref_clk, rst_n, stby, pg, wr_en, tle, thm, rsel, unl;
  logic [7:0] addr, wdata, rdata, rdata_v;
  ctpr_setpt_t setpt;
  int mismatches, check_count;
  // Row: address, data, expected 0x09 readback, expected key
  logic [31:0] rows [9] = '{32'h09ff0000, 32'h0aff0003, 32'h09ffc903, 32'h0a08c902, 32'h0900c902,
    32'h0a0cc903, 32'h09414103, 32'h09808003, 32'h0a048001};
  ctpr_host HOST (.ref_clk(ref_clk), .wr_en(wr_en), .addr(addr), .wdata(wdata));
  ctpr_regs #(.THM_OFF_RST(1'b0)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .wr_en(wr_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .standby_supply(stby), .safe_output_power_good(pg),
    .temp_loop_en(tle), .die_temp_setpoint(setpt), .thermistor_monitor_off(thm),
    .safety_region_select(rsel), .setting_unlocked(unl));
  // Variant whose thermistor bit defaults to stopped
  ctpr_regs #(.THM_OFF_RST(1'b1)) DUT_V (.ref_clk(ref_clk), .rst_n(rst_n), .wr_en(wr_en), .addr(addr),
    .wdata(wdata), .rdata(rdata_v), .standby_supply(stby), .safe_output_power_good(pg),
    .temp_loop_en(), .die_temp_setpoint(), .thermistor_monitor_off(),
    .safety_region_select(), .setting_unlocked());
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic state(input logic [7:0] e, input logic [1:0] k);
    HOST.rd(8'h09);
    chk(rdata, e);
    chk({2'h0, tle, setpt, thm, rsel, unl}, {2'h0, e[7:6] != 2'h3, e[7:6], e[3], e[0], k == 2'h3});
    HOST.rd(8'h0a);
    chk(rdata, {4'h0, k, 2'h0});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #20000;
    mismatches++;
    report_and_stop;
  end
  initial begin
    mismatches = 0;
    check_count = 0;
    rst_n = 1'b0;
    stby = 1'b1;
    pg = 1'b0;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    state(8'h00, 2'h0);
    HOST.rd(8'h09);
    chk(rdata_v, 8'h08);
    foreach (rows[i]) begin
      HOST.wr(rows[i][31:24], rows[i][23:16]);
      state(rows[i][15:8], rows[i][1:0]);
    end
    HOST.rd(8'h3c);
    chk(rdata, 8'h00);
    $display("write rows done");
    @(negedge ref_clk) pg = 1'b1;
    @(negedge ref_clk);
    state(8'h00, 2'h0);
    // Power-good held high must not keep clearing
    HOST.wr(8'h0a, 8'h0c);
    HOST.wr(8'h09, 8'hc1);
    state(8'hc1, 2'h3);
    @(negedge ref_clk) stby = 1'b0;
    @(negedge ref_clk) stby = 1'b1;
    state(8'h00, 2'h0);
    HOST.rd(8'h09);
    chk(rdata_v, 8'h08);
    $display("reset events done");
    // Reset pulse in mid-run after non-default settings
    HOST.wr(8'h0a, 8'h0c);
    HOST.wr(8'h09, 8'h49);
    state(8'h49, 2'h3);
    @(negedge ref_clk) rst_n = 1'b0;
    @(negedge ref_clk) rst_n = 1'b1;
    state(8'h00, 2'h0);
    HOST.rd(8'h09);
    chk(rdata_v, 8'h08);
    $display("mid-run reset done");
    report_and_stop;
  end
endmodule
`default_nettype wire
